// *** logic/afe_level_params.svh ***
// register offsets, field positions and reset values of the level control bank
`ifndef AFE_LEVEL_PARAMS_SVH
`define AFE_LEVEL_PARAMS_SVH
`define ADDR_BLUE_COARSE_OFFSET 8'h1E
`define ADDR_GREEN_COARSE_OFFSET 8'h1F
`define ADDR_RED_COARSE_OFFSET 8'h20
`define ADDR_HSYNC_OUT_START 8'h21
`define ADDR_MISC_CONTROL 8'h22
`define ADDR_LEVEL_CONTROL_ENABLE 8'h26
`define ADDR_LEVEL_CONTROL_FILTER 8'h28
`define ADDR_FINE_CLAMP_CONTROL 8'h2A
`define ADDR_POWER_CONTROL 8'h2B
`define RST_COARSE_OFFSET 6'h20
`define RST_HSYNC_OUT_START 8'h09
`define COARSE_OFFSET_MSB 5
`define MISC_COPY_PROTECT_BIT 3
`define MISC_VERTICAL_SYNC_ALIGN_SELECT_BIT 1
`define LEVEL_ENABLE_BIT 7
`define FILTER_VERT_LSB 3
`define FILTER_VERT_MSB 6
`define FILTER_HORZ_MSB 2
`define CLAMP_TC_LSB 3
`define CLAMP_TC_MSB 4
`define PD_SYNC_ON_GREEN_BIT 6
`define PD_SLICER_BIT 5
`define PD_REFERENCE_BIT 4
`define PD_CURRENT_BIT 3
`define PD_BLUE_BIT 2
`define PD_GREEN_BIT 1
`define PD_RED_BIT 0
`endif

// *** logic/afe_level_pkg.sv ***
// types shared by the level control register bank
package afe_level_pkg;
   typedef struct packed {
      logic blue;
      logic green;
      logic red;
   } rgb_flags_type;

   typedef struct packed {
      logic sync_on_green;
      logic slicer;
      logic reference;
      logic current_ctrl;
      rgb_flags_type converter;
   } powerdown_type;

   typedef struct packed {
      logic signed [6:0] blue;
      logic signed [6:0] green;
      logic signed [6:0] red;
   } rgb_steps_type;

   typedef struct packed {
      logic enable;
      logic [3:0] vertical_shift;
      logic [2:0] horizontal_shift;
   } level_ctrl_type;
endpackage : afe_level_pkg

// *** logic/video_afe_offset_level_control_regs.sv ***
// control register bank for coarse offsets, level control, clamp and power
`timescale 1ns/100ps
`include "afe_level_params.svh"
module video_afe_offset_level_control_regs (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   output afe_level_pkg::rgb_steps_type o_coarse_steps,
   output logic [7:0] o_hsync_out_start,
   output logic o_copy_protect_compat_enable,
   output logic o_vertical_sync_align_select,
   output afe_level_pkg::level_ctrl_type o_auto_level_control,
   output logic [1:0] o_fine_clamp_time_const,
   output afe_level_pkg::rgb_flags_type o_fine_clamp_enable,
   output afe_level_pkg::powerdown_type o_powerdown
);
   import afe_level_pkg::*;

   // ------------------------------------------------------------
   // offset code decode
   // ------------------------------------------------------------
   function automatic logic signed [6:0] offset_steps(
      input logic [5:0] code
   );
      logic signed [6:0] mag;
      mag = signed'({2'b00, code[4:0]});
      if (code[5]) begin
         offset_steps = -mag - 7'sd1;
      end else begin
         offset_steps = mag;
      end
   endfunction : offset_steps

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic addr_hit(
      input logic [7:0] addr,
      input logic [7:0] reg_addr
   );
      addr_hit = (addr == reg_addr);
   endfunction : addr_hit

   function automatic logic wr_hit(
      input logic [7:0] addr,
      input logic wr_en,
      input logic [7:0] reg_addr
   );
      wr_hit = wr_en && addr_hit(addr, reg_addr);
   endfunction : wr_hit

   // ------------------------------------------------------------
   // coarse offsets
   // ------------------------------------------------------------
   logic [5:0] blue_coarse_offset_r, blue_coarse_offset_nxt;
   logic [5:0] green_coarse_offset_r, green_coarse_offset_nxt;
   logic [5:0] red_coarse_offset_r, red_coarse_offset_nxt;

   always_comb begin
      blue_coarse_offset_nxt = blue_coarse_offset_r;
      green_coarse_offset_nxt = green_coarse_offset_r;
      red_coarse_offset_nxt = red_coarse_offset_r;
      // reserved bits are dropped on write
      if (wr_hit(i_addr, i_wr_en, `ADDR_BLUE_COARSE_OFFSET)) begin
         blue_coarse_offset_nxt =
            i_wr_data[`COARSE_OFFSET_MSB:0];
      end
      if (wr_hit(i_addr, i_wr_en, `ADDR_GREEN_COARSE_OFFSET)) begin
         green_coarse_offset_nxt =
            i_wr_data[`COARSE_OFFSET_MSB:0];
      end
      if (wr_hit(i_addr, i_wr_en, `ADDR_RED_COARSE_OFFSET)) begin
         red_coarse_offset_nxt =
            i_wr_data[`COARSE_OFFSET_MSB:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         blue_coarse_offset_r <= `RST_COARSE_OFFSET;
         green_coarse_offset_r <= `RST_COARSE_OFFSET;
         red_coarse_offset_r <= `RST_COARSE_OFFSET;
      end else begin
         blue_coarse_offset_r <= blue_coarse_offset_nxt;
         green_coarse_offset_r <= green_coarse_offset_nxt;
         red_coarse_offset_r <= red_coarse_offset_nxt;
      end
   end

   // ------------------------------------------------------------
   // sync start and misc control
   // ------------------------------------------------------------
   logic [7:0] hsync_out_start_r, hsync_out_start_nxt;
   logic copy_protect_r, copy_protect_nxt;
   logic vertical_sync_align_select_r, vertical_sync_align_select_nxt;

   always_comb begin
      hsync_out_start_nxt = hsync_out_start_r;
      copy_protect_nxt = copy_protect_r;
      vertical_sync_align_select_nxt = vertical_sync_align_select_r;
      if (wr_hit(i_addr, i_wr_en, `ADDR_HSYNC_OUT_START)) begin
         hsync_out_start_nxt = i_wr_data;
      end
      if (wr_hit(i_addr, i_wr_en, `ADDR_MISC_CONTROL)) begin
         copy_protect_nxt = i_wr_data[`MISC_COPY_PROTECT_BIT];
         vertical_sync_align_select_nxt = i_wr_data[`MISC_VERTICAL_SYNC_ALIGN_SELECT_BIT];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         hsync_out_start_r <= `RST_HSYNC_OUT_START;
         copy_protect_r <= 1'b0;
         vertical_sync_align_select_r <= 1'b0;
      end else begin
         hsync_out_start_r <= hsync_out_start_nxt;
         copy_protect_r <= copy_protect_nxt;
         vertical_sync_align_select_r <= vertical_sync_align_select_nxt;
      end
   end

   // ------------------------------------------------------------
   // automatic level control
   // ------------------------------------------------------------
   logic level_enable_r, level_enable_nxt;
   logic [3:0] level_vertical_coeff_r, level_vertical_coeff_nxt;
   logic [2:0] level_horizontal_coeff_r, level_horizontal_coeff_nxt;

   always_comb begin
      level_enable_nxt = level_enable_r;
      level_vertical_coeff_nxt = level_vertical_coeff_r;
      level_horizontal_coeff_nxt = level_horizontal_coeff_r;
      if (wr_hit(i_addr, i_wr_en, `ADDR_LEVEL_CONTROL_ENABLE)) begin
         level_enable_nxt = i_wr_data[`LEVEL_ENABLE_BIT];
      end
      if (wr_hit(i_addr, i_wr_en, `ADDR_LEVEL_CONTROL_FILTER)) begin
         level_vertical_coeff_nxt =
            i_wr_data[`FILTER_VERT_MSB:`FILTER_VERT_LSB];
         level_horizontal_coeff_nxt =
            i_wr_data[`FILTER_HORZ_MSB:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         level_enable_r <= 1'b0;
         level_vertical_coeff_r <= 4'h0;
         level_horizontal_coeff_r <= 3'h0;
      end else begin
         level_enable_r <= level_enable_nxt;
         level_vertical_coeff_r <= level_vertical_coeff_nxt;
         level_horizontal_coeff_r <= level_horizontal_coeff_nxt;
      end
   end

   // ------------------------------------------------------------
   // fine clamp
   // ------------------------------------------------------------
   logic [1:0] clamp_tc_r, clamp_tc_nxt;
   logic [2:0] clamp_en_r, clamp_en_nxt;

   always_comb begin
      clamp_tc_nxt = clamp_tc_r;
      clamp_en_nxt = clamp_en_r;
      if (wr_hit(i_addr, i_wr_en, `ADDR_FINE_CLAMP_CONTROL)) begin
         clamp_tc_nxt =
            i_wr_data[`CLAMP_TC_MSB:`CLAMP_TC_LSB];
         clamp_en_nxt = i_wr_data[`PD_BLUE_BIT:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         clamp_tc_r <= 2'h0;
         clamp_en_r <= 3'h0;
      end else begin
         clamp_tc_r <= clamp_tc_nxt;
         clamp_en_r <= clamp_en_nxt;
      end
   end

   // ------------------------------------------------------------
   // power-down
   // ------------------------------------------------------------
   logic [6:0] power_r, power_nxt;

   always_comb begin
      power_nxt = power_r;
      if (wr_hit(i_addr, i_wr_en, `ADDR_POWER_CONTROL)) begin
         power_nxt = i_wr_data[`PD_SYNC_ON_GREEN_BIT:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         power_r <= 7'h00;
      end else begin
         power_r <= power_nxt;
      end
   end

   // ------------------------------------------------------------
   // register images, reserved bits zero
   // ------------------------------------------------------------
   logic [7:0] blue_offset_word;
   logic [7:0] green_offset_word;
   logic [7:0] red_offset_word;
   logic [7:0] hsync_start_word;
   logic [7:0] misc_word;
   logic [7:0] level_enable_word;
   logic [7:0] level_filter_word;
   logic [7:0] fine_clamp_word;
   logic [7:0] power_word;

   assign blue_offset_word = {2'b00, blue_coarse_offset_r};
   assign green_offset_word = {2'b00, green_coarse_offset_r};
   assign red_offset_word = {2'b00, red_coarse_offset_r};
   assign hsync_start_word = hsync_out_start_r;
   assign misc_word = {4'h0, copy_protect_r, 1'b0, vertical_sync_align_select_r, 1'b0};
   assign level_enable_word = {level_enable_r, 7'h00};
   assign level_filter_word =
      {1'b0, level_vertical_coeff_r, level_horizontal_coeff_r};
   assign fine_clamp_word = {3'h0, clamp_tc_r, clamp_en_r};
   assign power_word = {1'b0, power_r};

   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   logic [7:0] rd_data_r, rd_data_nxt;
   logic rd_valid_r, rd_valid_nxt;

   always_comb begin
      rd_data_nxt = rd_data_r;
      rd_valid_nxt = i_rd_en;
      if (i_rd_en) begin
         // reserved and unmapped bits read zero
         case (i_addr)
            `ADDR_BLUE_COARSE_OFFSET: begin
               rd_data_nxt = blue_offset_word;
            end
            `ADDR_GREEN_COARSE_OFFSET: begin
               rd_data_nxt = green_offset_word;
            end
            `ADDR_RED_COARSE_OFFSET: begin
               rd_data_nxt = red_offset_word;
            end
            `ADDR_HSYNC_OUT_START: begin
               rd_data_nxt = hsync_start_word;
            end
            `ADDR_MISC_CONTROL: begin
               rd_data_nxt = misc_word;
            end
            `ADDR_LEVEL_CONTROL_ENABLE: begin
               rd_data_nxt = level_enable_word;
            end
            `ADDR_LEVEL_CONTROL_FILTER: begin
               rd_data_nxt = level_filter_word;
            end
            `ADDR_FINE_CLAMP_CONTROL: begin
               rd_data_nxt = fine_clamp_word;
            end
            `ADDR_POWER_CONTROL: begin
               rd_data_nxt = power_word;
            end
            default: begin
               rd_data_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rd_data_r <= 8'h00;
         rd_valid_r <= 1'b0;
      end else begin
         rd_data_r <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   // ------------------------------------------------------------
   // control outputs
   // ------------------------------------------------------------
   assign o_rd_data = rd_data_r;
   assign o_rd_valid = rd_valid_r;
   // host programs +31 for best level control
   assign o_coarse_steps.blue = offset_steps(blue_coarse_offset_r);
   assign o_coarse_steps.green =
      offset_steps(green_coarse_offset_r);
   assign o_coarse_steps.red = offset_steps(red_coarse_offset_r);
   assign o_hsync_out_start = hsync_out_start_r;
   assign o_copy_protect_compat_enable = copy_protect_r;
   assign o_vertical_sync_align_select = vertical_sync_align_select_r;

   // ------------------------------------------------------------
   // level control outputs
   // ------------------------------------------------------------
   assign o_auto_level_control.enable = level_enable_r;
   // vertical shift n means correction times 1/2^n per line
   assign o_auto_level_control.vertical_shift = level_vertical_coeff_r;
   // horizontal shift n means 2^n samples averaged
   assign o_auto_level_control.horizontal_shift = level_horizontal_coeff_r;

   // ------------------------------------------------------------
   // fine clamp outputs
   // ------------------------------------------------------------
   assign o_fine_clamp_time_const = clamp_tc_r;
   assign o_fine_clamp_enable = clamp_en_r;

   // ------------------------------------------------------------
   // power-down outputs
   // ------------------------------------------------------------
   assign o_powerdown.sync_on_green = power_r[`PD_SYNC_ON_GREEN_BIT];
   assign o_powerdown.slicer = power_r[`PD_SLICER_BIT];
   assign o_powerdown.reference = power_r[`PD_REFERENCE_BIT];
   assign o_powerdown.current_ctrl = power_r[`PD_CURRENT_BIT];
   assign o_powerdown.converter.blue = power_r[`PD_BLUE_BIT];
   assign o_powerdown.converter.green = power_r[`PD_GREEN_BIT];
   assign o_powerdown.converter.red = power_r[`PD_RED_BIT];
endmodule : video_afe_offset_level_control_regs

// *** sim/video_afe_offset_level_control_regs_sva.sv ***
// assertions on the ports of the level control register bank
`timescale 1ns/100ps
module video_afe_offset_level_control_regs_sva (
   input logic i_clk,
   input logic i_srst,
   input logic i_wr_en,
   input logic i_rd_en,
   input logic [7:0] i_addr,
   input logic [7:0] i_wr_data,
   input logic [7:0] o_rd_data,
   input logic o_rd_valid,
   input afe_level_pkg::rgb_steps_type o_coarse_steps,
   input logic [7:0] o_hsync_out_start,
   input logic o_copy_protect_compat_enable,
   input logic o_vertical_sync_align_select,
   input afe_level_pkg::level_ctrl_type o_auto_level_control,
   input logic [1:0] o_fine_clamp_time_const,
   input afe_level_pkg::rgb_flags_type o_fine_clamp_enable,
   input afe_level_pkg::powerdown_type o_powerdown
);
   import afe_level_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   function automatic logic [6:0] stp(input logic [7:0] c);
      return c[5] ? ~{2'h0, c[4:0]} : {2'h0, c[4:0]};
   endfunction : stp
   chk_blue_offset_map: assert property (
      i_wr_en && i_addr == 8'h1e |=>
      o_coarse_steps.blue == stp($past(i_wr_data)))
      else $error("blue offset step wrong");
   chk_green_offset_map: assert property (
      i_wr_en && i_addr == 8'h1f |=>
      o_coarse_steps.green == stp($past(i_wr_data)))
      else $error("green offset step wrong");
   chk_red_offset_map: assert property (
      i_wr_en && i_addr == 8'h20 |=>
      o_coarse_steps.red == stp($past(i_wr_data)))
      else $error("red offset step wrong");
   chk_hsync_start_write: assert property (
      i_wr_en && i_addr == 8'h21 |=> o_hsync_out_start == $past(i_wr_data))
      else $error("hsync start not written");
   chk_hsync_read: assert property (
      i_rd_en && i_addr == 8'h21 |=>
      o_rd_valid && o_rd_data == $past(o_hsync_out_start))
      else $error("hsync start read wrong");
   chk_misc_bits: assert property (
      i_wr_en && i_addr == 8'h22 |=> {o_copy_protect_compat_enable,
      o_vertical_sync_align_select} == {$past(i_wr_data[3]), $past(i_wr_data[1])})
      else $error("misc bits wrong");
   chk_level_enable: assert property (
      i_wr_en && i_addr == 8'h26 |=>
      o_auto_level_control.enable == $past(i_wr_data[7]))
      else $error("level enable wrong");
   chk_level_filter: assert property (
      i_wr_en && i_addr == 8'h28 |=>
      o_auto_level_control[6:0] == $past(i_wr_data[6:0]))
      else $error("level filter wrong");
   chk_clamp_fields: assert property (
      i_wr_en && i_addr == 8'h2a |=> {o_fine_clamp_time_const,
      o_fine_clamp_enable} == $past(i_wr_data[4:0]))
      else $error("fine clamp fields wrong");
   chk_power_bits: assert property (
      i_wr_en && i_addr == 8'h2b |=> o_powerdown == $past(i_wr_data[6:0]))
      else $error("power bits wrong");
endmodule : video_afe_offset_level_control_regs_sva

// *** sim/tb_video_afe_offset_level_control_regs.sv ***
// self-checking bench for the level control register bank
`timescale 1ns/100ps
module tb_video_afe_offset_level_control_regs;
   import afe_level_pkg::*;
   logic i_clk, i_srst, i_wr_en, i_rd_en, o_rd_valid;
   logic [7:0] i_addr, i_wr_data, o_rd_data, o_hsync_out_start, d, q[$];
   logic o_copy_protect_compat_enable, o_vertical_sync_align_select;
   rgb_steps_type o_coarse_steps;
   level_ctrl_type o_auto_level_control;
   logic [1:0] o_fine_clamp_time_const;
   rgb_flags_type o_fine_clamp_enable;
   powerdown_type o_powerdown;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   logic [7:0] m[9];
   logic [7:0] ad[9] = '{8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h26,
      8'h28, 8'h2a, 8'h2b};
   logic [7:0] mk[9] = '{8'h3f, 8'h3f, 8'h3f, 8'hff, 8'h0a, 8'h80,
      8'h7f, 8'h1f, 8'h7f};
   logic [7:0] rv[9] = '{8'h20, 8'h20, 8'h20, 8'h09, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00};
   logic [7:0] cd[5] = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'hdf};
   video_afe_offset_level_control_regs video_afe_offset_level_control_regs_inst (
      .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
      .o_rd_valid(o_rd_valid), .o_coarse_steps(o_coarse_steps),
      .o_hsync_out_start(o_hsync_out_start),
      .o_copy_protect_compat_enable(o_copy_protect_compat_enable),
      .o_vertical_sync_align_select(o_vertical_sync_align_select),
      .o_auto_level_control(o_auto_level_control),
      .o_fine_clamp_time_const(o_fine_clamp_time_const),
      .o_fine_clamp_enable(o_fine_clamp_enable), .o_powerdown(o_powerdown));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [6:0] stp(logic [7:0] c);
      return c[5] ? 7'(31 - int'(c[5:0])) : 7'(c[5:0]);
   endfunction : stp
   task automatic cmp(string n, logic [50:0] e, logic [50:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic ctl();
      cmp("controls", {stp(m[0]), stp(m[1]), stp(m[2]), m[3], m[4][3],
         m[4][1], m[5][7], m[6][6:0], m[7][4:0], m[8][6:0]},
         {o_coarse_steps, o_hsync_out_start, o_copy_protect_compat_enable,
         o_vertical_sync_align_select, o_auto_level_control,
         o_fine_clamp_time_const, o_fine_clamp_enable, o_powerdown});
   endtask : ctl
   task automatic acc(bit w, bit r, logic [7:0] a, logic [7:0] v);
      int k;
      k = 9;
      i_wr_en = w;
      i_rd_en = r;
      i_addr = a;
      i_wr_data = v;
      for (int j = 0; j < 9; j++) if (ad[j] == a) k = j;
      if (r) q.push_back(k < 9 ? m[k] : 8'h00);
      if (w && k < 9) m[k] = v & mk[k];
      @(negedge i_clk);
   endtask : acc
   task automatic rst();
      i_srst = 1;
      repeat (3) @(negedge i_clk);
      i_srst = 0;
      m = rv;
   endtask : rst
   task automatic read_all();
      for (int j = 0; j < 9; j++) acc(0, 1, ad[j], 8'h00);
      acc(0, 0, 8'h00, 8'h00);
      acc(0, 0, 8'h00, 8'h00);
   endtask : read_all
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   // ------------------------------------------------------------
   // clock, monitor, timeout and sequence
   // ------------------------------------------------------------
   initial begin
      i_clk = 0;
      forever #50 i_clk = ~i_clk;
   end
   always @(negedge i_clk) begin
      if (o_rd_valid === 1'b1) begin
         cmp("read expected", 51'h1, 51'(q.size() != 0));
         cmp("read data", q.pop_front(), o_rd_data);
      end
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      i_srst = 1;
      i_wr_en = 0;
      i_rd_en = 0;
      i_addr = 8'h00;
      i_wr_data = 8'h00;
      void'($urandom(32'h8cad_70f1));
      rst();
      ctl();
      read_all();
      $display("test reset values done");
      for (int j = 0; j < 3; j++) begin
         foreach (cd[c]) begin
            acc(1, 0, ad[j], c < 4 ? cd[c] : 8'($urandom));
            ctl();
         end
      end
      $display("test offset codes done");
      repeat (30) begin
         d = 8'($urandom);
         acc(1, 0, ad[$urandom % 9], d);
         ctl();
      end
      acc(1, 0, 8'h23, d);
      ctl();
      acc(0, 1, 8'h23, 8'h00);
      acc(1, 1, 8'h21, d ^ 8'hff);
      read_all();
      $display("test random access done");
      rst();
      ctl();
      read_all();
      $display("test second reset done");
      cmp("read queue empty", 51'h0, 51'(q.size()));
      stop_test();
   end
endmodule : tb_video_afe_offset_level_control_regs
bind video_afe_offset_level_control_regs
   video_afe_offset_level_control_regs_sva sva_inst (
   .i_clk(i_clk), .i_srst(i_srst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
   .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
   .o_rd_valid(o_rd_valid), .o_coarse_steps(o_coarse_steps),
   .o_hsync_out_start(o_hsync_out_start),
   .o_copy_protect_compat_enable(o_copy_protect_compat_enable),
   .o_vertical_sync_align_select(o_vertical_sync_align_select),
   .o_auto_level_control(o_auto_level_control),
   .o_fine_clamp_time_const(o_fine_clamp_time_const),
   .o_fine_clamp_enable(o_fine_clamp_enable), .o_powerdown(o_powerdown));
